// ==== verilog/fst_pkg.sv ====
// fst_pkg: register map, instruction fields, flag layout and engine states
// of the three-operand float subtract unit.
// assumes: included first; every fst_* file except fst_rf_if imports it.
package fst_pkg;
   // axi4-lite byte offsets (word aligned)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_INSTR = 8'h04;
   localparam logic [7:0] OFS_MOP1 = 8'h08;
   localparam logic [7:0] OFS_MOP2 = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [7:0] OFS_INT_STAT = 8'h18;
   localparam logic [7:0] OFS_INT_CLR = 8'h1C;
   localparam logic [7:0] OFS_INT_EN = 8'h20;
   // register file window 0x40..0x7f: rn mantissa at +8n, exponent +8n+4
   localparam logic [1:0] RF_WIN = 2'b01;
   // instruction fields
   localparam int MODE_LO = 21;
   localparam int DST_LO = 16;
   localparam int DST_W = 5;
   localparam int SRC1_LO = 8;
   localparam int SRC2_LO = 0;
   localparam int SEL_W = 3;
   // condition flag bit positions
   localparam int FLG_C = 0;
   localparam int FLG_V = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_N = 3;
   localparam int FLG_UF = 4;
   localparam int FLG_LV = 5;
   localparam int FLG_LUF = 6;
   localparam int FLAGS_W = 7;
   // interrupt events
   localparam int INT_DONE = 0;
   localparam int INT_OVF = 1;
   localparam int INT_UNF = 2;
   localparam int INT_W = 3;
   // number format
   localparam int EXT_W = 40;
   localparam int FRAC_W = 31;
   localparam int ACC_W = 37;
   localparam logic [7:0] EXP_ZERO = 8'h80;
   localparam logic [7:0] EXP_MAX = 8'h7F;
   // reset values
   localparam logic [31:0] RST_INSTR = 32'h0000_0000;
   localparam logic [6:0] RST_FLAGS = 7'h00;
   localparam logic [2:0] RST_INT_EN = 3'h0;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // engine states, gray along idle -> fetch -> exec; exec -> idle flips both bits
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC = 2'b11
   } fst_state_t;
endpackage : fst_pkg

// ==== verilog/fst_rf_if.sv ====
// fst_rf_if: ports of the extended-precision register file.
// assumes: one owner drives addresses and writes; reads are registered.
`timescale 1ns/1ps
`default_nettype none
interface fst_rf_if;
   logic [2:0] addr_a;
   logic [2:0] addr_b;
   logic [2:0] waddr;
   logic [39:0] wdata;
   logic [4:0] wbe;
   logic [39:0] rdata_a;
   logic [39:0] rdata_b;
   modport owner(output addr_a, addr_b, waddr, wdata, wbe,
                 input rdata_a, rdata_b);
   modport mem(input addr_a, addr_b, waddr, wdata, wbe,
               output rdata_a, rdata_b);
endinterface : fst_rf_if
`default_nettype wire

// ==== verilog/fst_regfile.sv ====
// fst_regfile: eight 40-bit registers r0..r7, two registered read ports
// and one byte-enabled write port.
// assumes: single clock; contents are data and need no reset.
`timescale 1ns/1ps
`default_nettype none
module fst_regfile (
   // clock
   input wire logic aclk,
   // register file port
   fst_rf_if.mem rf
);
   import fst_pkg::*;

   typedef struct packed {
      logic [7:0][39:0] regs;
      logic [39:0] ra;
      logic [39:0] rb;
   } fst_rf_t;

   fst_rf_t s_r;
   fst_rf_t s_nxt;

   // read before write: a read in the write cycle sees the old word
   always_comb begin
      s_nxt = s_r;
      s_nxt.ra = s_r.regs[rf.addr_a];
      s_nxt.rb = s_r.regs[rf.addr_b];
      for (int i = 0; i < 5; i++) begin
         if (rf.wbe[i]) begin
            s_nxt.regs[rf.waddr][i*8 +: 8] = rf.wdata[i*8 +: 8];
         end
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   assign rf.rdata_a = s_r.ra;
   assign rf.rdata_b = s_r.rb;
endmodule : fst_regfile
`default_nettype wire

// ==== verilog/fst_top.sv ====
// fst_top: three-operand float subtract datapath with axi4-lite registers,
// condition flags and a level interrupt.
// assumes: one clock aclk, synchronous active-low aresetn, axi4-lite master.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fst_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // interrupt
   output logic irq
);
   import fst_pkg::*;

   typedef struct packed {
      fst_state_t st;
      logic [31:0] instr;
      logic sat_mode;
      logic [31:0] mop1;
      logic [31:0] mop2;
      logic [FLAGS_W-1:0] flags;
      logic bad_dst;
      logic [INT_W-1:0] int_stat;
      logic [INT_W-1:0] int_en;
      logic irq;
      logic awready;
      logic wready;
      logic awheld;
      logic wheld;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rd_pend;
      logic [7:0] araddr;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fst_top_t;

   fst_top_t s_r;
   fst_top_t s_nxt;

   fst_rf_if rf ();

   fst_regfile u_rf (
      .aclk(aclk),
      .rf(rf)
   );

   // byte-lane merge for software writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction : merge

   // 32-bit memory float widened to extended form, low bits zero
   function automatic logic [39:0] mem_to_ext(input logic [31:0] m);
      mem_to_ext = {m, 8'h00};
   endfunction : mem_to_ext

   // {zero, sign, magnitude}; magnitude is 1.f (pos) or 2-0.f (neg)
   function automatic logic [34:0] unpack(input logic [39:0] x);
      logic [32:0] mg;
      mg = 33'h1_0000_0000 - {2'b00, x[FRAC_W-1:0]};
      if (!x[31]) begin
         mg = {2'b01, x[FRAC_W-1:0]};
      end
      if (x[39:32] == EXP_ZERO) begin
         mg = '0;
      end
      unpack = {x[39:32] == EXP_ZERO, x[31], mg};
   endfunction : unpack

   // position of the most significant one
   function automatic logic [5:0] lead(input logic [ACC_W-1:0] x);
      lead = '0;
      for (int i = 0; i < ACC_W; i++) begin
         if (x[i]) begin
            lead = 6'(i);
         end
      end
   endfunction : lead

   // a - b in extended float; returns {overflow, underflow, result}
   function automatic logic [41:0] fsub(input logic [39:0] a,
                                        input logic [39:0] b);
      logic [34:0] ua;
      logic [34:0] ub;
      logic signed [9:0] ea;
      logic signed [9:0] eb;
      logic signed [9:0] emax;
      logic signed [9:0] er;
      logic signed [9:0] diff;
      logic signed [ACC_W-1:0] va;
      logic signed [ACC_W-1:0] vb;
      logic signed [ACC_W-1:0] sum;
      logic [ACC_W-1:0] mag;
      logic [ACC_W-1:0] nm;
      logic [5:0] p;
      logic [31:0] m;
      logic [31:0] f;
      logic [39:0] res;
      logic ov;
      logic uf;
      ua = unpack(a);
      ub = unpack(b);
      ea = 10'($signed(a[39:32]));
      eb = 10'($signed(b[39:32]));
      va = {4'b0000, ua[32:0]};
      vb = {4'b0000, ub[32:0]};
      if (ua[33]) va = -va;
      // subtraction: second operand enters with sign turned
      if (!ub[33]) vb = -vb;
      diff = ea - eb;
      emax = ea;
      // align the smaller exponent; far-off operands vanish
      if (diff >= 0) begin
         vb = (diff > 10'sd36) ? '0 : $signed(vb >>> diff[5:0]);
      end else begin
         emax = eb;
         diff = -diff;
         va = (diff > 10'sd36) ? '0 : $signed(va >>> diff[5:0]);
      end
      sum = va + vb;
      mag = sum[ACC_W-1] ? ACC_W'(-sum) : sum;
      p = lead(mag);
      if (p >= 6'd31) nm = mag >> (p - 6'd31);
      else nm = mag << (6'd31 - p);
      er = emax + $signed({4'b0000, p}) - 10'sd31;
      // repack into two's complement mantissa
      m = {1'b0, nm[FRAC_W-1:0]};
      if (sum[ACC_W-1]) begin
         f = 32'h0000_0000 - nm[31:0];
         m = {1'b1, f[FRAC_W-1:0]};
         if (nm[FRAC_W-1:0] == '0) begin
            er = er - 10'sd1;
            m = 32'h8000_0000;
         end
      end
      ov = (mag != '0) && (er > 10'sd127);
      uf = (mag != '0) && (er < -10'sd127);
      res = {er[7:0], m};
      // overflow saturates to the largest value of the result's sign
      if (ov) res = sum[ACC_W-1] ? {EXP_MAX, 32'h8000_0000}
                                 : {EXP_MAX, 32'h7FFF_FFFF};
      if (uf || mag == '0) res = {EXP_ZERO, 32'h0000_0000};
      fsub = {ov, uf, res};
   endfunction : fsub

   logic [1:0] mode;
   logic [DST_W-1:0] dst;
   assign mode = s_r.instr[MODE_LO +: 2];
   assign dst = s_r.instr[DST_LO +: DST_W];

   // next-state logic: bus slave, engine, flags and interrupt
   always_comb begin
      logic [39:0] op1;
      logic [39:0] op2;
      logic [41:0] fr;
      logic [INT_W-1:0] ev;
      logic [INT_W-1:0] clr;
      logic [31:0] rv;
      s_nxt = s_r;
      ev = '0;
      clr = '0;
      rv = 32'h0000_0000;
      // source fields sit by encoding position, not assembly order
      op1 = mode[0] ? mem_to_ext(s_r.mop1) : rf.rdata_a;
      op2 = mode[1] ? mem_to_ext(s_r.mop2) : rf.rdata_b;
      // sat_mode is deliberately not an input here
      fr = fsub(op1, op2);
      rf.addr_a = (s_r.st == ST_FETCH) ? s_r.instr[SRC1_LO +: SEL_W]
                                       : araddr[5:3];
      rf.addr_b = s_r.instr[SRC2_LO +: SEL_W];
      rf.waddr = (s_r.st == ST_EXEC) ? dst[SEL_W-1:0] : s_r.awaddr[5:3];
      rf.wdata = (s_r.st == ST_EXEC) ? fr[39:0]
                                     : {s_r.wdata[7:0], s_r.wdata};
      rf.wbe = '0;

      // write address and data are taken independently
      if (awvalid && s_r.awready) begin
         s_nxt.awaddr = awaddr;
         s_nxt.awheld = 1'b1;
      end
      if (wvalid && s_r.wready) begin
         s_nxt.wdata = wdata;
         s_nxt.wstrb = wstrb;
         s_nxt.wheld = 1'b1;
      end
      if (s_r.bvalid && bready) s_nxt.bvalid = 1'b0;

      // writes wait for an idle engine so registers never tear mid-op
      if (s_r.awheld && s_r.wheld && !s_r.bvalid && s_r.st == ST_IDLE) begin
         s_nxt.awheld = 1'b0;
         s_nxt.wheld = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         if (s_r.awaddr[7:6] == RF_WIN) begin
            rf.wbe = s_r.awaddr[2] ? {s_r.wstrb[0], 4'b0000}
                                   : {1'b0, s_r.wstrb};
         end else begin
            unique case ({s_r.awaddr[7:2], 2'b00})
               OFS_CTRL: if (s_r.wstrb[0]) s_nxt.sat_mode = s_r.wdata[0];
               OFS_INSTR: begin
                  s_nxt.instr = merge(s_r.instr, s_r.wdata, s_r.wstrb);
                  s_nxt.st = ST_FETCH;
               end
               OFS_MOP1: s_nxt.mop1 = merge(s_r.mop1, s_r.wdata, s_r.wstrb);
               OFS_MOP2: s_nxt.mop2 = merge(s_r.mop2, s_r.wdata, s_r.wstrb);
               OFS_FLAGS: if (s_r.wstrb[0]) begin
                  s_nxt.flags = s_r.wdata[FLAGS_W-1:0];
               end
               OFS_INT_CLR: if (s_r.wstrb[0]) clr = s_r.wdata[INT_W-1:0];
               OFS_INT_EN: if (s_r.wstrb[0]) begin
                  s_nxt.int_en = s_r.wdata[INT_W-1:0];
               end
               OFS_STAT, OFS_INT_STAT: ;
               default: s_nxt.bresp = RESP_SLVERR;
            endcase
         end
      end

      // engine: fetch reads both sources, exec writes back
      unique case (s_r.st)
         ST_IDLE: ;
         ST_FETCH: s_nxt.st = ST_EXEC;
         ST_EXEC: begin
            s_nxt.st = ST_IDLE;
            ev[INT_DONE] = 1'b1;
            s_nxt.bad_dst = dst[DST_W-1:SEL_W] != '0;
            // only r0..r7 are legal targets
            if (dst[DST_W-1:SEL_W] == '0) begin
               rf.wbe = '1;
               s_nxt.flags[FLG_LUF] = s_r.flags[FLG_LUF] | fr[40];
               s_nxt.flags[FLG_LV] = s_r.flags[FLG_LV] | fr[41];
               s_nxt.flags[FLG_UF] = fr[40];
               s_nxt.flags[FLG_N] = fr[31];
               s_nxt.flags[FLG_Z] = fr[39:32] == EXP_ZERO;
               s_nxt.flags[FLG_V] = fr[41];  // carry kept
               ev[INT_OVF] = fr[41];
               ev[INT_UNF] = fr[40];
            end
         end
      endcase

      // reads take one cycle to gather register file data
      if (arvalid && s_r.arready) begin
         s_nxt.araddr = araddr;
         s_nxt.rd_pend = 1'b1;
      end
      if (s_r.rvalid && rready) s_nxt.rvalid = 1'b0;
      if (s_r.rd_pend) begin
         s_nxt.rd_pend = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         if (s_r.araddr[7:6] == RF_WIN) begin
            rv = s_r.araddr[2] ? {24'h00_0000, rf.rdata_a[39:32]}
                               : rf.rdata_a[31:0];
         end else begin
            unique case ({s_r.araddr[7:2], 2'b00})
               OFS_CTRL: rv = {31'h0000_0000, s_r.sat_mode};
               OFS_INSTR: rv = s_r.instr;
               OFS_MOP1: rv = s_r.mop1;
               OFS_MOP2: rv = s_r.mop2;
               OFS_FLAGS: rv = {25'h000_0000, s_r.flags};
               OFS_STAT: rv = {30'h0000_0000, s_r.bad_dst,
                               s_r.st != ST_IDLE};
               OFS_INT_STAT: rv = {29'h0000_0000, s_r.int_stat};
               OFS_INT_EN: rv = {29'h0000_0000, s_r.int_en};
               OFS_INT_CLR: ;
               default: s_nxt.rresp = RESP_SLVERR;
            endcase
         end
         s_nxt.rdata = rv;
      end

      // sticky events: a set in the clear cycle survives
      s_nxt.int_stat = (s_r.int_stat & ~clr) | ev;
      s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_en);
      s_nxt.awready = !s_nxt.awheld;
      s_nxt.wready = !s_nxt.wheld;
      s_nxt.arready = !s_nxt.rd_pend && !s_nxt.rvalid
                      && s_nxt.st == ST_IDLE;
   end

   // single state register, synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.instr <= RST_INSTR;
         s_r.flags <= RST_FLAGS;
         s_r.int_en <= RST_INT_EN;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign awready = s_r.awready;
   assign wready = s_r.wready;
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign arready = s_r.arready;
   assign rvalid = s_r.rvalid;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;
   assign irq = s_r.irq;
endmodule : fst_top
`default_nettype wire

// ==== verif/fst_properties.sv ====
// fst_properties: handshake, latency and interrupt checks on fst_top ports.
// assumes: bound to fst_top below; one clock aclk, sync reset aresetn.
`timescale 1ns/1ps
`default_nettype none
module fst_properties
   import fst_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write side
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   // read side
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // interrupt
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a read answers on a fixed schedule, two edges after it is taken
   property p_rd_lat;
      arvalid && arready |=> !rvalid ##1 rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer off");
   // read data holds until taken, then the port reopens
   property p_rd_hold;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_rd_end;
      rvalid && rready |=> !rvalid && arready;
   endproperty
   a_rd_end: assert property (p_rd_end) else $error("read not closed");
   // engine busy may delay the answer by at most two cycles
   property p_b_lat;
      awvalid && awready && wvalid && wready |-> ##[1:4] bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write answer late");
   property p_w_take;
      awvalid && awready && wvalid && wready |=> !awready && !wready;
   endproperty
   a_w_take: assert property (p_w_take) else $error("write port open");
   property p_b_end;
      bvalid && bready |=> !bvalid;
   endproperty
   a_b_end: assert property (p_b_end) else $error("write not closed");
   // reset leaves every answer idle and the address ports open
   property p_rst;
      $rose(aresetn) |-> awready && arready && !bvalid && !rvalid && !irq;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   // unmapped and write-only places read back as zero
   property p_rd_err;
      arvalid && arready && araddr inside {[8'h24:8'h3C]} |->
         ##2 rvalid && rresp == RESP_SLVERR && rdata == 32'h0000_0000;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read ok");
   property p_clr_rd;
      arvalid && arready && araddr == OFS_INT_CLR |->
         ##2 rvalid && rdata == 32'h0000_0000;
   endproperty
   a_clr_rd: assert property (p_clr_rd) else $error("clear reg readable");
   // clearing every event drops the level output
   property p_irq_clr;
      awvalid && awready && awaddr == OFS_INT_CLR && wvalid && wready &&
         wdata[2:0] == 3'h7 |-> ##[1:6] !irq;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq stuck");
endmodule : fst_properties
bind fst_top fst_properties u_props (.aclk(aclk), .aresetn(aresetn),
   .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
   .irq(irq));
`default_nettype wire

// ==== verif/tb_top.sv ====
// tb_top: self-checking bench for fst_top driven as an axi4-lite master.
// assumes: fst_pkg and the bound checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fst_pkg::*;
   typedef struct {logic [31:0] d; logic [1:0] r;} fst_exp_t;
   logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, awready, wready, arready, bvalid;
   logic rvalid, irq;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   logic [4:0] dst;
   // expected results of modes 00..11 with r1, r2, mop1 and mop2 below
   logic [39:0] mode_res [4] = '{40'h05_1D00_0000, 40'h06_E4A0_0000,
                                 40'h07_26FE_0000, 40'h05_4838_0000};
   logic [6:0] mode_flg [4] = '{7'h01, 7'h09, 7'h01, 7'h01};
   int err_count = 0;
   int cmp_count = 0;
   fst_exp_t expq[$];
   fst_exp_t e;
   fst_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .irq(irq));
   // 25 MHz clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   // monitor: every answer taken is matched against the oldest note
   always @(posedge aclk) begin
      if ((bvalid && bready) || (rvalid && rready)) begin
         e = expq.pop_front();
         chk(rvalid ? rdata : 32'h0000_0000, e.d);
         chk({30'h0, rvalid ? rresp : bresp}, {30'h0, e.r});
      end
   end
   // one write; a spare edge at the end keeps drivers single per step
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = RESP_OKAY);
      logic done = 1'b0;
      expq.push_back('{32'h0000_0000, r});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // no cycle budget here: only the watchdog ends a stuck wait
      while (!done) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = RESP_OKAY);
      logic done = 1'b0;
      expq.push_back('{d, r});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      @(posedge aclk);
   endtask : rd
   // registers are two words: mantissa, then exponent in the low byte
   task automatic wreg(input logic [2:0] n, input logic [39:0] v);
      wr(8'h40 + {2'b00, n, 3'b000}, v[31:0]);
      wr(8'h44 + {2'b00, n, 3'b000}, {24'h00_0000, v[39:32]});
   endtask : wreg
   task automatic run(input logic [31:0] ins, input logic [2:0] n,
                      input logic [39:0] v, input logic [6:0] f);
      wr(OFS_INSTR, ins);
      rd(8'h40 + {2'b00, n, 3'b000}, v[31:0]);
      rd(8'h44 + {2'b00, n, 3'b000}, {24'h00_0000, v[39:32]});
      rd(OFS_FLAGS, {25'h0, f});
   endtask : run
   function automatic logic [31:0] mk(input logic [1:0] m,
      input logic [4:0] d, input logic [2:0] s1, input logic [2:0] s2);
      return {9'h000, m, d, 5'h00, s1, 5'h00, s2};
   endfunction : mk
   // watchdog: the run needs a few hundred cycles, this allows 20000
   initial begin
      #(40 * 20000);
      err_count++;
      results();
   end
   // main sequence
   initial begin
      void'($urandom(32'h2cf5));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_CTRL, 32'h0000_0000);
      rd(OFS_INSTR, RST_INSTR);
      rd(OFS_FLAGS, {25'h0, RST_FLAGS});
      rd(OFS_INT_EN, {29'h0, RST_INT_EN});
      rd(OFS_INT_CLR, 32'h0000_0000);
      rd(8'h30, 32'h0000_0000, RESP_SLVERR);
      wr(8'h30, 32'h0000_0001, RESP_SLVERR);
      $display("test reset done");
      wreg(3'd7, 40'h05_7B40_0000);
      wreg(3'd0, 40'h03_4C20_0000);
      wr(OFS_FLAGS, 32'h0000_0001);
      for (int m = 0; m < 2; m++) begin
         wr(OFS_CTRL, 32'(m));
         run(mk(2'b00, 5'd6, 3'd0, 3'd7), 3'd6,
             40'h05_B7C8_0000, 7'h09);
      end
      wr(OFS_CTRL, 32'h0000_0000);
      $display("test register subtract done");
      wr(OFS_MOP1, 32'h057B_4000);
      wr(OFS_MOP2, 32'h034C_2000);
      wreg(3'd1, 40'h07_33C0_0000);
      wreg(3'd2, 40'h07_0C80_0000);
      // every mode picks a different pair, so a swapped mode bit shows
      for (int m = 0; m < 4; m++) begin
         dst = 5'(3 + $urandom % 5);
         run(mk(2'(m), dst, 3'd1, 3'd2), dst[2:0],
             mode_res[m], mode_flg[m]);
      end
      $display("test operand modes done");
      wr(OFS_INT_CLR, 32'h0000_0007);
      wreg(3'd3, 40'h7F_7FFF_FFFF);
      wreg(3'd4, 40'h7F_8000_0000);
      run(mk(2'b00, 5'd5, 3'd3, 3'd4), 3'd5,
          40'h7F_7FFF_FFFF, 7'h23);
      rd(OFS_INT_STAT, 32'h0000_0003);
      run(mk(2'b00, 5'd6, 3'd1, 3'd2), 3'd6,
          40'h05_1D00_0000, 7'h21);
      wreg(3'd3, 40'h81_4000_0000);
      wreg(3'd4, 40'h81_0000_0000);
      run(mk(2'b00, 5'd5, 3'd3, 3'd4), 3'd5,
          40'h80_0000_0000, 7'h75);
      rd(OFS_INT_STAT, 32'h0000_0007);
      run(mk(2'b00, 5'd6, 3'd1, 3'd1), 3'd6,
          40'h80_0000_0000, 7'h65);
      $display("test overflow underflow done");
      // an illegal target must not alias onto r0 nor touch the flags
      dst = 5'(8 + $urandom % 24);
      run(mk(2'b00, dst, 3'd7, 3'd1), 3'd0,
          40'h03_4C20_0000, 7'h65);
      rd(OFS_STAT, 32'h0000_0002);
      $display("test illegal target done");
      wr(OFS_INT_CLR, 32'h0000_0007);
      wr(OFS_INT_EN, 32'h0000_0001);
      run(mk(2'b00, 5'd6, 3'd1, 3'd2), 3'd6,
          40'h05_1D00_0000, 7'h61);
      wr(OFS_INT_STAT, 32'h0000_0007);
      rd(OFS_INT_STAT, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(OFS_INT_EN, 32'h0000_0000);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(OFS_INT_EN, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0000_0001);
      // clear all while irq is high, so the checker's clear test bites
      wr(OFS_INT_CLR, 32'h0000_0007);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(OFS_INT_STAT, 32'h0000_0000);
      $display("test interrupt done");
      results();
   end
endmodule : tb_top
`default_nettype wire
